/* agen_defs.vh */
// Purpose: constants for the paged and circular address generator
// Assumes: 32-bit APB, one register per aligned word
// Notes: offsets are byte addresses
`ifndef AGEN_DEFS_VH
`define AGEN_DEFS_VH

`define OFS_CONTROL 12'h000
`define OFS_X_START 12'h004
`define OFS_X_END 12'h008
`define OFS_Y_START 12'h00C
`define OFS_Y_END 12'h010
`define OFS_READ_PAGE 12'h014
`define OFS_WRITE_PAGE 12'h018
`define OFS_STATUS 12'h01C

`define XSEL_LSB 0
`define YSEL_LSB 4
`define XEN_BIT 15
`define YEN_BIT 14
`define SEL_OFF 4'hF
`define DIR_X_BIT 8
`define DIR_Y_BIT 9

`define CONTROL_RESET 16'h00FF
`define READ_PAGE_RESET 10'h001
`define WRITE_PAGE_RESET 9'h001

`endif

/* ptr_file.v */
// Purpose: sixteen 16-bit working pointers with registered read ports
// Assumes: one write port, two read ports
// Notes: read data appears one cycle after the index
`timescale 1ns/100ps
module ptr_file #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [15:0] wdata,
    input wire [AW-1:0] raddr_a,
    input wire [AW-1:0] raddr_b,
    output reg [15:0] rdata_a,
    output reg [15:0] rdata_b
);
    reg [15:0] mem [0:DEPTH-1];
    integer i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= 16'h0000;
            end
            rdata_a <= 16'h0000;
            rdata_b <= 16'h0000;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule

/* paged_modulo_address_gen.v */
// Purpose: paged extended addresses and circular pointer update
// Assumes: single pclk domain, core signals synchronous to pclk
// Notes: registers over APB; pointers live in ptr_file
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "agen_defs.vh"
module paged_modulo_address_gen (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ea_valid,
    input wire ea_write,
    input wire [15:0] effective_address,
    input wire mod_valid,
    input wire mod_is_y,
    input wire [3:0] mod_ptr,
    input wire signed [15:0] mod_step,
    input wire ptr_load,
    input wire [3:0] ptr_load_idx,
    input wire [15:0] ptr_load_data,
    input wire [3:0] ptr_rd_idx,
    output reg [23:0] ext_read_addr,
    output reg ext_read_valid,
    output reg program_space_window,
    output reg [23:0] ext_write_addr,
    output reg ext_write_valid,
    output reg [15:0] base_addr,
    output reg base_valid,
    output reg [15:0] ptr_rd_data,
    output reg mod_done,
    output reg [15:0] mod_new_ptr,
    output reg mod_wrapped
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_FETCH = 3'b010;
    localparam ST_UPDATE = 3'b100;

    reg [15:0] control_reg;
    reg [15:0] x_start_reg;
    reg [15:0] x_end_reg;
    reg [15:0] y_start_reg;
    reg [15:0] y_end_reg;
    reg [9:0] read_page_reg;
    reg [8:0] write_page_reg;
    reg [1:0] wrap_seen_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg op_is_y_reg;
    reg [3:0] op_ptr_reg;
    reg signed [15:0] op_step_reg;

    wire [15:0] ptr_old;
    wire [15:0] ptr_port_b;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function active;
        input [3:0] sel;
        input en;
        begin
            active = (sel != `SEL_OFF) && en;
        end
    endfunction

    function is_pow2_len;
        input [15:0] s;
        input [15:0] e;
        reg [15:0] len;
        begin
            len = e - s + 16'h0001;
            is_pow2_len = (len != 16'h0000) && ((len & (len - 16'h0001)) == 16'h0000);
        end
    endfunction

    wire [3:0] x_pointer_select = control_reg[`XSEL_LSB+3:`XSEL_LSB];
    wire [3:0] y_pointer_select = control_reg[`YSEL_LSB+3:`YSEL_LSB];
    wire x_circular_enable = control_reg[`XEN_BIT];
    wire y_circular_enable = control_reg[`YEN_BIT];
    wire x_active = active(x_pointer_select, x_circular_enable);
    wire y_active = active(y_pointer_select, y_circular_enable);

    // ----------------------------------------
    // pointer store
    // ----------------------------------------
    wire upd_we = (state_reg == ST_UPDATE);
    reg [15:0] upd_value;
    reg upd_wrap;

    ptr_file #(
        .DEPTH(16),
        .AW(4)
    ) u_ptrs (
        .clk(pclk),
        .rst_n(presetn),
        .we(upd_we | ptr_load),
        .waddr(upd_we ? op_ptr_reg : ptr_load_idx),
        .wdata(upd_we ? upd_value : ptr_load_data),
        .raddr_a(mod_valid && state_reg == ST_IDLE ? mod_ptr : op_ptr_reg),
        .raddr_b(ptr_rd_idx),
        .rdata_a(ptr_old),
        .rdata_b(ptr_port_b)
    );

    // ----------------------------------------
    // circular update
    // ----------------------------------------
    // at most one buffer per space; pointer must match the space select
    reg [15:0] b_start;
    reg [15:0] b_end;
    reg b_on;
    reg b_down;
    reg [16:0] sum;
    reg [15:0] raw;
    always @* begin
        b_start = op_is_y_reg ? y_start_reg : x_start_reg;
        b_end = op_is_y_reg ? y_end_reg : x_end_reg;
        b_on = op_is_y_reg ? (y_active && op_ptr_reg == y_pointer_select)
                           : (x_active && op_ptr_reg == x_pointer_select);
        b_down = op_is_y_reg ? control_reg[`DIR_Y_BIT] : control_reg[`DIR_X_BIT];
        sum = {1'b0, ptr_old} + {op_step_reg[15], op_step_reg};
        raw = sum[15:0];
        if (op_is_y_reg) begin
            raw[0] = 1'b0;
        end
        upd_value = raw;
        upd_wrap = 1'b0;
        if (b_on) begin
            // length is implied by start and end alone
            if (is_pow2_len(b_start, b_end)) begin
                if (!op_step_reg[15] && (raw > b_end || sum[16])) begin
                    upd_value = b_start + (raw - b_end - 16'h0001);
                    upd_wrap = 1'b1;
                end else if (op_step_reg[15] && (raw < b_start || sum[16])) begin
                    upd_value = b_end - (b_start - raw - 16'h0001);
                    upd_wrap = 1'b1;
                end
            end else if (!b_down && raw > b_end) begin
                upd_value = b_start;
                upd_wrap = 1'b1;
            end else if (b_down && raw < b_start) begin
                upd_value = b_end;
                upd_wrap = 1'b1;
            end
            if (op_is_y_reg) begin
                upd_value[0] = 1'b0;
            end
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (mod_valid) begin
                    state_next = ST_FETCH;
                end
            end
            ST_FETCH: begin
                state_next = ST_UPDATE;
            end
            ST_UPDATE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            op_is_y_reg <= 1'b0;
            op_ptr_reg <= 4'h0;
            op_step_reg <= 16'h0000;
            mod_done <= 1'b0;
            mod_new_ptr <= 16'h0000;
            mod_wrapped <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && mod_valid) begin
                op_is_y_reg <= mod_is_y;
                op_ptr_reg <= mod_ptr;
                op_step_reg <= mod_step;
            end
            mod_done <= upd_we;
            if (upd_we) begin
                mod_new_ptr <= upd_value;
                mod_wrapped <= upd_wrap;
            end
        end
    end

    // ----------------------------------------
    // paged address forming
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_read_addr <= 24'h000000;
            ext_read_valid <= 1'b0;
            program_space_window <= 1'b0;
            ext_write_addr <= 24'h000000;
            ext_write_valid <= 1'b0;
            base_addr <= 16'h0000;
            base_valid <= 1'b0;
            ptr_rd_data <= 16'h0000;
        end else begin
            ptr_rd_data <= ptr_port_b;
            ext_read_valid <= 1'b0;
            ext_write_valid <= 1'b0;
            base_valid <= 1'b0;
            program_space_window <= 1'b0;
            if (ea_valid) begin
                if (!effective_address[15]) begin
                    base_addr <= effective_address;
                    base_valid <= 1'b1;
                end else if (ea_write) begin
                    ext_write_addr <= {write_page_reg, effective_address[14:0]};
                    ext_write_valid <= 1'b1;
                end else if (!read_page_reg[9]) begin
                    ext_read_addr <= {read_page_reg[8:0], effective_address[14:0]};
                    ext_read_valid <= 1'b1;
                end else begin
                    // page bit9 set selects the program-space window
                    ext_read_addr <= {read_page_reg[8:0], effective_address[14:0]};
                    program_space_window <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    wire acc = psel && penable && !pready;
    reg [31:0] rd_mux;
    reg hit;
    always @* begin
        hit = 1'b1;
        rd_mux = 32'h00000000;
        if (paddr == `OFS_CONTROL) begin
            rd_mux = {16'h0000, control_reg};
        end else if (paddr == `OFS_X_START) begin
            rd_mux = {16'h0000, x_start_reg};
        end else if (paddr == `OFS_X_END) begin
            rd_mux = {16'h0000, x_end_reg};
        end else if (paddr == `OFS_Y_START) begin
            rd_mux = {16'h0000, y_start_reg};
        end else if (paddr == `OFS_Y_END) begin
            rd_mux = {16'h0000, y_end_reg};
        end else if (paddr == `OFS_READ_PAGE) begin
            rd_mux = {22'h000000, read_page_reg};
        end else if (paddr == `OFS_WRITE_PAGE) begin
            rd_mux = {23'h000000, write_page_reg};
        end else if (paddr == `OFS_STATUS) begin
            rd_mux = {28'h0000000, wrap_seen_reg, y_active, x_active};
        end else begin
            hit = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            control_reg <= `CONTROL_RESET;
            x_start_reg <= 16'h0000;
            x_end_reg <= 16'h0000;
            y_start_reg <= 16'h0000;
            y_end_reg <= 16'h0000;
            read_page_reg <= `READ_PAGE_RESET;
            write_page_reg <= `WRITE_PAGE_RESET;
            wrap_seen_reg <= 2'b00;
        end else begin
            pready <= acc;
            pslverr <= acc && !hit;
            if (acc && !pwrite) begin
                prdata <= rd_mux;
            end
            // a wrap in the same cycle as a clear stays set
            if (acc && pwrite && paddr == `OFS_STATUS) begin
                wrap_seen_reg <= (wrap_seen_reg & ~pwdata[3:2])
                               | {upd_we && upd_wrap && op_is_y_reg,
                                  upd_we && upd_wrap && !op_is_y_reg};
            end else begin
                wrap_seen_reg <= wrap_seen_reg
                               | {upd_we && upd_wrap && op_is_y_reg,
                                  upd_we && upd_wrap && !op_is_y_reg};
            end
            if (acc && pwrite) begin
                if (paddr == `OFS_CONTROL) begin
                    control_reg <= pwdata[15:0];
                end else if (paddr == `OFS_X_START) begin
                    x_start_reg <= pwdata[15:0];
                end else if (paddr == `OFS_X_END) begin
                    x_end_reg <= pwdata[15:0];
                end else if (paddr == `OFS_Y_START) begin
                    y_start_reg <= pwdata[15:0];
                end else if (paddr == `OFS_Y_END) begin
                    y_end_reg <= pwdata[15:0];
                end else if (paddr == `OFS_READ_PAGE) begin
                    read_page_reg <= pwdata[9:0];
                end else if (paddr == `OFS_WRITE_PAGE) begin
                    write_page_reg <= pwdata[8:0];
                end
            end
        end
    end
endmodule

/* agen_chk.sv */
// Purpose: port checker for paged_modulo_address_gen
// Assumes: page and control shadows follow APB writes
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`include "agen_defs.vh"
module agen_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire ea_valid,
    input wire ea_write,
    input wire [15:0] effective_address,
    input wire mod_valid,
    input wire mod_is_y,
    input wire [23:0] ext_read_addr,
    input wire ext_read_valid,
    input wire program_space_window,
    input wire [23:0] ext_write_addr,
    input wire ext_write_valid,
    input wire [15:0] base_addr,
    input wire base_valid,
    input wire mod_done,
    input wire mod_wrapped
);
    logic [9:0] rp_reg;
    logic [8:0] wp_reg;
    logic [15:0] ctl_reg;
    wire wr = psel && penable && pready && pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rp_reg <= `READ_PAGE_RESET;
            wp_reg <= `WRITE_PAGE_RESET;
            ctl_reg <= `CONTROL_RESET;
        end else if (wr) begin
            if (paddr == `OFS_READ_PAGE) rp_reg <= pwdata[9:0];
            if (paddr == `OFS_WRITE_PAGE) wp_reg <= pwdata[8:0];
            if (paddr == `OFS_CONTROL) ctl_reg <= pwdata[15:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rd_ext;
        logic [23:0] a;
        (ea_valid && !ea_write && effective_address[15] && !rp_reg[9],
         a = {rp_reg[8:0], effective_address[14:0]})
        |=> ext_read_valid && !program_space_window && ext_read_addr == a;
    endproperty
    a_rd_ext: assert property (p_rd_ext) else $error("bad paged read");
    property p_wr_ext;
        logic [23:0] a;
        (ea_valid && ea_write && effective_address[15], a = {wp_reg, effective_address[14:0]})
        |=> ext_write_valid && ext_write_addr == a;
    endproperty
    a_wr_ext: assert property (p_wr_ext) else $error("bad paged write");
    property p_psv;
        ea_valid && !ea_write && effective_address[15] && rp_reg[9]
        |=> program_space_window && !ext_read_valid;
    endproperty
    a_psv: assert property (p_psv) else $error("window read missing");
    property p_base;
        logic [15:0] a;
        (ea_valid && !effective_address[15], a = effective_address)
        |=> base_valid && base_addr == a && !ext_read_valid && !ext_write_valid;
    endproperty
    a_base: assert property (p_base) else $error("bad base access");
    property p_ready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not one pulse");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_done;
        mod_done |-> $past(mod_valid, 3);
    endproperty
    a_done: assert property (p_done) else $error("done without request");
    property p_x_off;
        mod_done && !$past(mod_is_y, 3) && (ctl_reg[3:0] == 4'hF || !ctl_reg[15])
        |-> !mod_wrapped;
    endproperty
    a_x_off: assert property (p_x_off) else $error("x wrap while off");
    property p_y_off;
        mod_done && $past(mod_is_y, 3) && (ctl_reg[7:4] == 4'hF || !ctl_reg[14])
        |-> !mod_wrapped;
    endproperty
    a_y_off: assert property (p_y_off) else $error("y wrap while off");
    c_ext: cover property (ext_read_valid);
    c_wrap: cover property (mod_done && mod_wrapped);
    c_err: cover property (pslverr);
endmodule

bind paged_modulo_address_gen agen_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ea_valid(ea_valid), .ea_write(ea_write),
    .effective_address(effective_address), .mod_valid(mod_valid), .mod_is_y(mod_is_y),
    .ext_read_addr(ext_read_addr), .ext_read_valid(ext_read_valid),
    .program_space_window(program_space_window), .ext_write_addr(ext_write_addr),
    .ext_write_valid(ext_write_valid), .base_addr(base_addr), .base_valid(base_valid),
    .mod_done(mod_done), .mod_wrapped(mod_wrapped));

/* core_model.sv */
// Purpose: core side issuing addresses and pointer updates
// Assumes: requests start just after a rising pclk edge
// Notes: released address, load data and step fields show the inverse of their last value
`timescale 1ns/100ps
module core_model (
    input wire pclk,
    output logic ea_valid,
    output logic ea_write,
    output logic [15:0] effective_address,
    output logic mod_valid,
    output logic mod_is_y,
    output logic [3:0] mod_ptr,
    output logic [15:0] mod_step,
    output logic ptr_load,
    output logic [3:0] ptr_load_idx,
    output logic [15:0] ptr_load_data
);
    initial begin
        {ea_valid, ea_write, effective_address, mod_valid, mod_is_y} = '0;
        {mod_ptr, mod_step, ptr_load, ptr_load_idx, ptr_load_data} = '0;
    end
    task automatic access(input logic w, input logic [15:0] a);
        @(posedge pclk);
        ea_valid <= 1'b1;
        ea_write <= w;
        effective_address <= a;
        @(posedge pclk);
        ea_valid <= 1'b0;
        effective_address <= ~a;
    endtask
    // load the pointer, then ask for one step on it
    task automatic modify(input logic y, input logic [3:0] p, input logic [15:0] v,
                          input logic [15:0] s);
        @(posedge pclk);
        ptr_load <= 1'b1;
        ptr_load_idx <= p;
        ptr_load_data <= v;
        @(posedge pclk);
        ptr_load <= 1'b0;
        ptr_load_data <= ~v;
        mod_valid <= 1'b1;
        mod_is_y <= y;
        mod_ptr <= p;
        mod_step <= s;
        @(posedge pclk);
        mod_valid <= 1'b0;
        mod_step <= ~s;
    endtask
endmodule

/* paged_modulo_address_gen_tb.sv */
// Purpose: self-checking bench for paged_modulo_address_gen
// Assumes: APB driven here, core side by core_model
// Notes: apb answers taken at the ready edge; core outputs on the falling edge
`timescale 1ns/100ps
`include "agen_defs.vh"
module paged_modulo_address_gen_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] rd_idx = 4'h0;
    logic [31:0] q;
    logic e;
    int miscompares = 0;
    int checks = 0;
    wire [31:0] prdata;
    wire pready, pslverr, ea_valid, ea_write, mod_valid, mod_is_y, ptr_load;
    wire [15:0] effective_address, mod_step, ptr_load_data, base_addr, mod_new_ptr, ptr_rd_data;
    wire [3:0] mod_ptr, ptr_load_idx;
    wire [23:0] ext_read_addr, ext_write_addr;
    wire ext_read_valid, program_space_window, ext_write_valid, base_valid;
    wire mod_done, mod_wrapped;
    always #50 pclk = ~pclk;
    core_model u_core (.pclk(pclk), .ea_valid(ea_valid), .ea_write(ea_write),
        .effective_address(effective_address), .mod_valid(mod_valid), .mod_is_y(mod_is_y),
        .mod_ptr(mod_ptr), .mod_step(mod_step), .ptr_load(ptr_load),
        .ptr_load_idx(ptr_load_idx), .ptr_load_data(ptr_load_data));
    paged_modulo_address_gen u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ea_valid(ea_valid), .ea_write(ea_write),
        .effective_address(effective_address), .mod_valid(mod_valid), .mod_is_y(mod_is_y),
        .mod_ptr(mod_ptr), .mod_step(mod_step), .ptr_load(ptr_load),
        .ptr_load_idx(ptr_load_idx), .ptr_load_data(ptr_load_data), .ptr_rd_idx(rd_idx),
        .ext_read_addr(ext_read_addr), .ext_read_valid(ext_read_valid),
        .program_space_window(program_space_window), .ext_write_addr(ext_write_addr),
        .ext_write_valid(ext_write_valid), .base_addr(base_addr), .base_valid(base_valid),
        .ptr_rd_data(ptr_rd_data), .mod_done(mod_done), .mod_new_ptr(mod_new_ptr),
        .mod_wrapped(mod_wrapped));
    task automatic summarize;
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // request held until the edge that sees ready high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1);
        if (n == 20) summarize();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // flags are read valid, window, write valid, base valid
    task automatic ea(input logic w, input logic [15:0] a, input logic [3:0] f,
                      input logic [23:0] x);
        u_core.access(w, a);
        @(negedge pclk);
        chk({28'h0, ext_read_valid, program_space_window, ext_write_valid, base_valid}, f);
        chk(f[0] ? {16'h0, base_addr} : {8'h0, f[1] ? ext_write_addr : ext_read_addr}, x);
    endtask
    task automatic md(input logic y, input logic [3:0] p, input logic [15:0] v,
                      input logic [15:0] s, input logic [15:0] x, input logic wrp);
        int n;
        u_core.modify(y, p, v, s);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (mod_done !== 1'b1 && n < 8);
        chk({14'h0, mod_done, mod_wrapped, mod_new_ptr}, {14'h0, 1'b1, wrp, x});
        if (n == 8) summarize();
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_CONTROL, 32'h00FF);
        rd(`OFS_READ_PAGE, 32'h001);
        rd(`OFS_WRITE_PAGE, 32'h001);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 12'(i * 4), 32'hFFFFFFFF);
            rd(12'(i * 4), i == 5 ? 32'h3FF : i == 6 ? 32'h1FF : 32'hFFFF);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk({e, q[30:0]}, 32'h80000000);
        apb(1'b1, `OFS_READ_PAGE, 32'h005);
        ea(1'b0, 16'h8123, 4'h8, 24'h028123);
        apb(1'b1, `OFS_WRITE_PAGE, 32'h1AB);
        ea(1'b1, 16'hFFFE, 4'h2, {9'h1AB, 15'h7FFE});
        ea(1'b0, 16'h7FFF, 4'h1, 24'h007FFF);
        ea(1'b1, 16'h0002, 4'h1, 24'h000002);
        apb(1'b1, `OFS_READ_PAGE, 32'h205);
        ea(1'b0, 16'h8004, 4'h4, 24'h028004);
        apb(1'b1, `OFS_X_START, 32'h1000);
        apb(1'b1, `OFS_X_END, 32'h1009);
        apb(1'b1, `OFS_Y_START, 32'h2000);
        apb(1'b1, `OFS_Y_END, 32'h2009);
        apb(1'b1, `OFS_CONTROL, 32'h80F2);
        md(1'b0, 4'h2, 16'h1008, 16'h0002, 16'h1000, 1'b1);
        md(1'b0, 4'h2, 16'h1000, 16'h0002, 16'h1002, 1'b0);
        md(1'b0, 4'h3, 16'h1008, 16'h0002, 16'h100A, 1'b0);
        apb(1'b1, `OFS_CONTROL, 32'h81F2);
        md(1'b0, 4'h2, 16'h1002, 16'hFFFC, 16'h1009, 1'b1);
        apb(1'b1, `OFS_CONTROL, 32'h00F2);
        md(1'b0, 4'h2, 16'h1008, 16'h0002, 16'h100A, 1'b0);
        apb(1'b1, `OFS_CONTROL, 32'h80FF);
        md(1'b0, 4'h2, 16'h1008, 16'h0002, 16'h100A, 1'b0);
        apb(1'b1, `OFS_CONTROL, 32'h402F);
        md(1'b1, 4'h2, 16'h2008, 16'h0002, 16'h2000, 1'b1);
        md(1'b1, 4'h2, 16'h2003, 16'h0002, 16'h2004, 1'b0);
        apb(1'b1, `OFS_CONTROL, 32'h002F);
        md(1'b1, 4'h2, 16'h2008, 16'h0002, 16'h200A, 1'b0);
        apb(1'b1, `OFS_X_END, 32'h1007);
        apb(1'b1, `OFS_CONTROL, 32'h80F2);
        md(1'b0, 4'h2, 16'h1000, 16'hFFFE, 16'h1006, 1'b1);
        md(1'b0, 4'h2, 16'h1004, 16'hFFFE, 16'h1002, 1'b0);
        rd(`OFS_STATUS, 32'hD);
        apb(1'b1, `OFS_STATUS, 32'hC);
        rd(`OFS_STATUS, 32'h1);
        @(posedge pclk);
        rd_idx <= 4'h2;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({16'h0, ptr_rd_data}, 32'h1002);
        summarize();
    end
endmodule
